/* File: common/alert_mask_strap_loop_regs.svh */
`ifndef ALERT_MASK_STRAP_LOOP_REGS_SVH
`define ALERT_MASK_STRAP_LOOP_REGS_SVH
// Command codes
`define CMD_ALERT_MASK 8'hdb
`define CMD_STRAP_READ 8'hdd
`define CMD_LOOP_TUNE 8'hdf
// Alert mask
`define MASK_RESET 56'h00_0000_0000_0000
// Strap readback byte positions (low bit of each byte)
`define STRAP_LOOP_LSB 48
`define STRAP_GEN_LSB 40
`define STRAP_SYNC_LSB 32
`define STRAP_LOCKOUT_LSB 24
`define STRAP_VSETA_LSB 16
`define STRAP_VSETB_LSB 8
`define STRAP_UNUSED_BYTE 8'hff
// Strap decode codes
`define STRAP_RES_MAX 8'h1e
`define STRAP_CODE_LOW 8'hf1
`define STRAP_CODE_OPEN 8'hf2
`define STRAP_CODE_HIGH 8'hf3
// Loop tuning layout and strap-derived defaults
`define LOOP_ENABLE_BIT 24
`define LOOP_RES_MASK 8'h7f
`define LOOP_BASE_GAIN 16'h0064
`define LOOP_GAIN_STEP 16'h001e
`define LOOP_BASE_RES 8'h0a
`define LOOP_RES_STEP 8'h02
`define NUM_PAGES 2
`endif

/* File: common/alert_mask_strap_loop_pkg.sv */
`default_nettype none
package alert_mask_strap_loop_pkg;
   typedef enum logic [1:0] {
      STRAP_RES = 2'h0,
      STRAP_LOW = 2'h1,
      STRAP_OPEN = 2'h2,
      STRAP_HIGH = 2'h3
   } strap_kind_t;
   typedef struct packed {
      strap_kind_t kind;
      logic [4:0] resIndex;
   } strap_pin_t;
   typedef struct packed {
      logic valid;
      logic write;
      logic page;
      logic [7:0] code;
      logic [55:0] data;
   } cmd_req_t;
   typedef struct packed {
      logic [6:0] unused;
      logic enable;
      logic [7:0] residual;
      logic [15:0] gain;
   } loop_cfg_t;
   typedef enum logic [1:0] {
      ST_WAIT_STRAP = 2'b01,
      ST_RUN = 2'b10
   } bank_state_t;
endpackage
`default_nettype wire

/* File: rtl/alert_mask_strap_loop_regs.sv */
`timescale 1ns/1ns
`default_nettype none
`include "alert_mask_strap_loop_regs.svh"

// How it works
// - A set mask bit keeps that fault type from asserting the alert pin.
// - Mask bit n of byte k guards status bit n of byte k, one to one.
// - After reset the mask reads as seven zero bytes, so nothing is masked.
// - Strap readback returns seven read-only global bytes: one code per strap pin for the six pins, then FF.
// - A resistor strap reads as code 00 to 1E, rising with the resistor value.
// - A low strap reads F1, an open one F2 and a high one F3.
// - Bits 55:48 carry the loop strap code and bits 47:40 the general strap code.
// - Bits 39:32 carry the sync strap code and bits 31:24 the undervoltage strap code.
// - Bits 23:16 and 15:8 carry the two voltage-set straps; the low byte reads FF.
// - Loop tuning is a four-byte per-page register reset from the loop strap.
// - Bit 24 enables the loop, 23:16 hold residual, 15:0 hold gain, 31:25 unused.
// - Gain and residual follow the measured values unless the host overrides them.
module alert_mask_strap_loop_regs
   import alert_mask_strap_loop_pkg::*;
(
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire cmd_req_t cmdReq,
   output logic rspValid,
   output logic rspRefused,
   output logic [55:0] rspData,
   input wire strap_pin_t loopStrap,
   input wire strap_pin_t genStrap,
   input wire strap_pin_t syncStrap,
   input wire strap_pin_t lockoutStrap,
   input wire strap_pin_t vsetStrapA,
   input wire strap_pin_t vsetStrapB,
   input wire logic [55:0] faultEvent,
   input wire logic faultClear,
   output logic [55:0] faultRecord,
   output logic faultAlertPinOut,
   output logic faultAlertPinOe,
   output logic strapReady,
   input wire logic [15:0] autoGain,
   input wire logic [7:0] autoResidual,
   output logic [`NUM_PAGES-1:0] loopEnable,
   output logic [`NUM_PAGES*16-1:0] loopGain,
   output logic [`NUM_PAGES*8-1:0] loopResidual
);

   // ********************************
   // Decode helpers
   // ********************************

   // Out-of-range resistor indices clamp to the top code
   function automatic logic [7:0] strapCode(input strap_pin_t pin);
      logic [7:0] idx;
      idx = {3'h0, pin.resIndex};
      unique case (pin.kind)
         STRAP_LOW: strapCode = `STRAP_CODE_LOW;
         STRAP_OPEN: strapCode = `STRAP_CODE_OPEN;
         STRAP_HIGH: strapCode = `STRAP_CODE_HIGH;
         STRAP_RES: strapCode = (idx > `STRAP_RES_MAX) ? `STRAP_RES_MAX : idx;
      endcase
   endfunction

   // Loop defaults from the loop strap; tie-low parks the loop off
   function automatic loop_cfg_t loopDefault(input logic [7:0] code);
      loop_cfg_t cfg;
      cfg = '0;
      cfg.enable = (code != `STRAP_CODE_LOW);
      cfg.gain = `LOOP_BASE_GAIN;
      cfg.residual = `LOOP_BASE_RES;
      if (code <= `STRAP_RES_MAX) begin
         cfg.gain = 16'(`LOOP_BASE_GAIN + 16'(code) * `LOOP_GAIN_STEP);
         cfg.residual = 8'(`LOOP_BASE_RES + code * `LOOP_RES_STEP);
      end
      loopDefault = cfg;
   endfunction

   // ********************************
   // Strap capture and bank state
   // ********************************

   bank_state_t state, next_state;
   logic [55:0] strapWord, next_strapWord;
   logic [55:0] alertMask, next_alertMask;
   loop_cfg_t loopReg [`NUM_PAGES];
   loop_cfg_t next_loopReg [`NUM_PAGES];
   logic [`NUM_PAGES-1:0] hostOverride, next_hostOverride;
   logic [55:0] next_faultRecord;
   logic next_rspValid, next_rspRefused, next_alertOe;
   logic [55:0] next_rspData;
   logic [7:0] loopCode;
   logic pageOk;

   assign loopCode = strapCode(loopStrap);
   assign pageOk = (32'(cmdReq.page) < `NUM_PAGES);

   // Straps are sampled once, the cycle after reset release, never under reset
   always_comb begin
      next_state = state;
      next_strapWord = strapWord;
      if (state == ST_WAIT_STRAP) begin
         next_state = ST_RUN;
         next_strapWord = {loopCode, strapCode(genStrap),
            strapCode(syncStrap), strapCode(lockoutStrap),
            strapCode(vsetStrapA), strapCode(vsetStrapB), `STRAP_UNUSED_BYTE};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state <= ST_WAIT_STRAP;
         strapWord <= {7{`STRAP_UNUSED_BYTE}};
      end else begin
         state <= next_state;
         strapWord <= next_strapWord;
      end
   end

   assign strapReady = (state == ST_RUN);

   // ********************************
   // Command handling
   // ********************************

   // Commands before straps settle are refused, so reads never show stale codes
   always_comb begin
      next_alertMask = alertMask;
      next_hostOverride = hostOverride;
      next_loopReg = loopReg;
      next_rspValid = cmdReq.valid;
      next_rspRefused = 1'b0;
      next_rspData = '0;
      if (state == ST_WAIT_STRAP) begin
         for (int p = 0; p < `NUM_PAGES; p++) begin
            next_loopReg[p] = loopDefault(loopCode);
         end
         next_hostOverride = '0;
         next_rspRefused = cmdReq.valid;
      end else if (cmdReq.valid) begin
         unique case (cmdReq.code)
            `CMD_ALERT_MASK: begin
               if (cmdReq.write) begin
                  next_alertMask = cmdReq.data;
               end
               next_rspData = alertMask;
            end
            `CMD_STRAP_READ: begin
               next_rspRefused = cmdReq.write;
               next_rspData = strapWord;
            end
            `CMD_LOOP_TUNE: begin
               if (!pageOk) begin
                  next_rspRefused = 1'b1;
               end else if (cmdReq.write) begin
                  // Unused bits and residual bit 7 read back zero
                  next_loopReg[cmdReq.page] = '0;
                  next_loopReg[cmdReq.page].enable = cmdReq.data[`LOOP_ENABLE_BIT];
                  next_loopReg[cmdReq.page].residual = cmdReq.data[23:16] & `LOOP_RES_MASK;
                  next_loopReg[cmdReq.page].gain = cmdReq.data[15:0];
                  next_hostOverride[cmdReq.page] = 1'b1;
                  next_rspData = {24'h00_0000, loopReg[cmdReq.page]};
               end else begin
                  next_rspData = {24'h00_0000, loopReg[cmdReq.page]};
               end
            end
            default: next_rspRefused = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         alertMask <= `MASK_RESET;
         hostOverride <= '0;
         for (int p = 0; p < `NUM_PAGES; p++) begin
            loopReg[p] <= '0;
         end
         rspValid <= 1'b0;
         rspRefused <= 1'b0;
         rspData <= '0;
      end else begin
         alertMask <= next_alertMask;
         hostOverride <= next_hostOverride;
         loopReg <= next_loopReg;
         rspValid <= next_rspValid;
         rspRefused <= next_rspRefused;
         rspData <= next_rspData;
      end
   end

   // ********************************
   // Fault record and alert pin
   // ********************************

   // Set wins over clear so a fault in the clearing cycle is kept
   always_comb begin
      next_faultRecord = (faultClear ? '0 : faultRecord) | faultEvent;
      next_alertOe = |(faultRecord & ~alertMask);
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         faultRecord <= '0;
         faultAlertPinOe <= 1'b0;
      end else begin
         faultRecord <= next_faultRecord;
         faultAlertPinOe <= next_alertOe;
      end
   end

   // Open-drain: the pin is only ever pulled low
   assign faultAlertPinOut = 1'b0;

   // ********************************
   // Effective loop settings
   // ********************************

   // Measured values rule until the host writes that page
   generate
      for (genvar g = 0; g < `NUM_PAGES; g++) begin : gLoop
         assign loopEnable[g] = loopReg[g].enable;
         assign loopGain[g*16 +: 16] = hostOverride[g] ? loopReg[g].gain : autoGain;
         assign loopResidual[g*8 +: 8] = hostOverride[g] ? loopReg[g].residual : autoResidual;
      end
   endgenerate

   // ********************************
   // Assertions
   // ********************************

   a_alert_masked_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ((faultRecord & ~alertMask) == '0) |=> !faultAlertPinOe)
      else $error("alert asserted with every recorded fault masked");

   a_alert_unmasked_fires: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ((faultRecord & ~alertMask) != '0) |=> faultAlertPinOe)
      else $error("unmasked fault did not raise alert");

   a_mask_reset_zero: assert property (@(posedge clk_sys)
      $fell(sys_rst) |-> alertMask == `MASK_RESET)
      else $error("mask not zero after reset");

   a_strap_read_only: assert property (@(posedge clk_sys) disable iff (sys_rst)
      strapReady && $past(strapReady) |-> $stable(strapWord))
      else $error("strap readback changed after capture");

   a_strap_low_byte: assert property (@(posedge clk_sys) disable iff (sys_rst)
      strapWord[7:0] == `STRAP_UNUSED_BYTE)
      else $error("strap low byte not FF");

   a_strap_codes_legal: assert property (@(posedge clk_sys) disable iff (sys_rst)
      strapReady |-> strapWord[`STRAP_LOOP_LSB +: 8] <= `STRAP_RES_MAX
         || strapWord[`STRAP_LOOP_LSB +: 8] inside {`STRAP_CODE_LOW, `STRAP_CODE_OPEN, `STRAP_CODE_HIGH})
      else $error("illegal loop strap code");

   a_fault_kept_masked: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (faultEvent != '0) |=> ((faultRecord & $past(faultEvent)) == $past(faultEvent)))
      else $error("fault event not recorded");

   a_loop_write_taken: assert property (@(posedge clk_sys) disable iff (sys_rst)
      strapReady && cmdReq.valid && cmdReq.write && cmdReq.code == `CMD_LOOP_TUNE && pageOk
      |=> loopReg[$past(cmdReq.page)].gain == $past(cmdReq.data[15:0]) && hostOverride[$past(cmdReq.page)])
      else $error("loop tuning write not taken");

   a_loop_auto_gain: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !hostOverride[0] |-> loopGain[15:0] == autoGain)
      else $error("gain not following measured value");

   a_rsp_one_cycle: assert property (@(posedge clk_sys) disable iff (sys_rst)
      cmdReq.valid |=> rspValid ##1 (rspValid == $past(cmdReq.valid)))
      else $error("answer not one cycle after request");

   c_masked_fault: cover property (@(posedge clk_sys) disable iff (sys_rst)
      (faultRecord != '0) && ((faultRecord & ~alertMask) == '0));
   c_strap_write: cover property (@(posedge clk_sys) disable iff (sys_rst)
      cmdReq.valid && cmdReq.write && cmdReq.code == `CMD_STRAP_READ ##1 rspRefused);
   c_loop_override: cover property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(hostOverride[1]));

endmodule
`default_nettype wire

/* File: sim/host_cmd_model.sv */
`timescale 1ns/1ns
`default_nettype none
module host_cmd_model
   import alert_mask_strap_loop_pkg::*;
(
   input wire logic clk_sys,
   output var cmd_req_t cmdReq,
   input wire logic rspValid,
   input wire logic rspRefused,
   input wire logic [55:0] rspData
);
   // ****************
   // Host side of the command port
   // ****************
   // Quiet at time zero
   initial begin
      cmdReq = '0;
   end

   // Valid stays up so calls may follow back to back
   task automatic issue(input logic w, input logic p, input logic [7:0] c, input logic [55:0] d,
      output logic [1:0] r, output logic [55:0] q);
      cmdReq = '{valid: 1'b1, write: w, page: p, code: c, data: d};
      @(posedge clk_sys);
      #1;
      r = {rspValid, rspRefused};
      q = rspData;
   endtask

   // Released data flips, so a stale word never reads as fresh
   task automatic idle();
      cmdReq.valid = 1'b0;
      cmdReq.data = ~cmdReq.data;
      // One quiet edge keeps the next request out of this time step
      @(posedge clk_sys);
      #1;
   endtask
endmodule
`default_nettype wire

/* File: sim/alert_mask_strap_loop_regs_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "alert_mask_strap_loop_regs.svh"
module alert_mask_strap_loop_regs_tb_top
   import alert_mask_strap_loop_pkg::*;
();
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   cmd_req_t cmdReq;
   logic rspValid, rspRefused, faultClear, faultAlertPinOut, faultAlertPinOe, strapReady;
   logic [55:0] rspData, faultEvent, faultRecord;
   strap_pin_t loopStrap, genStrap, syncStrap, lockoutStrap, vsetStrapA, vsetStrapB;
   logic [15:0] autoGain = 16'h0123;
   logic [7:0] autoResidual = 8'h45;
   logic [1:0] loopEnable;
   logic [31:0] loopGain;
   logic [15:0] loopResidual;
   int bad_count = 0;
   int checks = 0;

   host_cmd_model i_host (.clk_sys(clk_sys), .cmdReq(cmdReq), .rspValid(rspValid),
      .rspRefused(rspRefused), .rspData(rspData));
   alert_mask_strap_loop_regs i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmdReq(cmdReq),
      .rspValid(rspValid), .rspRefused(rspRefused), .rspData(rspData), .loopStrap(loopStrap),
      .genStrap(genStrap), .syncStrap(syncStrap), .lockoutStrap(lockoutStrap), .vsetStrapA(vsetStrapA),
      .vsetStrapB(vsetStrapB), .faultEvent(faultEvent), .faultClear(faultClear),
      .faultRecord(faultRecord), .faultAlertPinOut(faultAlertPinOut), .faultAlertPinOe(faultAlertPinOe),
      .strapReady(strapReady), .autoGain(autoGain), .autoResidual(autoResidual),
      .loopEnable(loopEnable), .loopGain(loopGain), .loopResidual(loopResidual));

   // ****************
   // Clock and watchdog
   // ****************
   always #5 clk_sys = ~clk_sys;

   // Whole run is about 115 cycles; over seventeen times that means a hang
   initial begin
      #20000;
      bad_count++;
      complete_run();
   end

   // ****************
   // Shared tasks
   // ****************
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [55:0] got, input logic [55:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   // Expected answer {valid, refused}; read data checked on accepted reads
   task automatic cmd(input logic w, input logic p, input logic [7:0] c, input logic [55:0] d,
      input logic [1:0] er, input logic [55:0] ed);
      logic [1:0] r;
      logic [55:0] q;
      i_host.issue(w, p, c, d, r, q);
      chk(56'(r), 56'(er));
      if (er == 2'b10 && !w) begin
         chk(q, ed);
      end
   endtask

   // Straps are only captured after reset, so they change here
   task automatic do_reset(input strap_pin_t ls);
      sys_rst = 1'b1;
      loopStrap = ls;
      repeat (20) @(posedge clk_sys);
      #1;
      sys_rst = 1'b0;
   endtask

   task automatic pulse(input int idx, input logic eo);
      faultEvent = 56'h1 << idx;
      @(posedge clk_sys);
      #1;
      faultEvent = '0;
      chk(faultRecord & (56'h1 << idx), 56'h1 << idx);
      @(posedge clk_sys);
      #1;
      chk(56'(faultAlertPinOe), 56'(eo));
   endtask

   task automatic clr();
      faultClear = 1'b1;
      @(posedge clk_sys);
      #1;
      faultClear = 1'b0;
      chk(faultRecord, '0);
      @(posedge clk_sys);
      #1;
      chk(56'({faultAlertPinOut, faultAlertPinOe}), '0);
   endtask

   // ****************
   // Scenarios
   // ****************
   task automatic t_strap();
      chk(56'(strapReady), '0);
      cmd(0, 0, `CMD_STRAP_READ, '0, 2'b11, '0);
      chk(56'(strapReady), 56'h1);
      cmd(0, 0, `CMD_ALERT_MASK, '0, 2'b10, 56'h00_0000_0000_0000);
      cmd(0, 1, `CMD_STRAP_READ, '0, 2'b10, 56'h05_f1f2_f300_1eff);
      cmd(1, 0, `CMD_STRAP_READ, 56'h12_3456_789a_bcde, 2'b11, '0);
      cmd(0, 0, `CMD_STRAP_READ, '0, 2'b10, 56'h05_f1f2_f300_1eff);
      cmd(0, 0, 8'hdc, '0, 2'b11, '0);
      i_host.idle();
      chk(56'(loopGain), 56'({autoGain, autoGain}));
      $display("strap test done");
   endtask

   task automatic t_loop();
      cmd(0, 0, `CMD_LOOP_TUNE, '0, 2'b10, 56'h00_0000_0114_00fa);
      cmd(1, 1, `CMD_LOOP_TUNE, 56'h00_0000_feda_03e8, 2'b10, '0);
      cmd(0, 1, `CMD_LOOP_TUNE, '0, 2'b10, 56'h00_0000_005a_03e8);
      i_host.idle();
      // New measured values must reach only the page the host left alone
      autoGain = 16'h0321;
      autoResidual = 8'h54;
      #1;
      chk(56'(loopGain), 56'({16'h03e8, autoGain}));
      chk(56'(loopResidual), 56'({8'h5a, autoResidual}));
      chk(56'(loopEnable), 56'h00_0000_0000_0001);
      $display("loop test done");
   endtask

   // One unmasked bit per byte, its neighbour masked
   task automatic t_alert();
      int b;
      for (int k = 0; k < 7; k++) begin
         b = k * 9;
         cmd(1, 0, `CMD_ALERT_MASK, ~(56'h1 << b), 2'b10, '0);
         i_host.idle();
         pulse(b ^ 1, 1'b0);
         pulse(b, 1'b1);
         clr();
      end
      cmd(0, 0, `CMD_ALERT_MASK, '0, 2'b10, ~(56'h1 << 54));
      i_host.idle();
      $display("alert test done");
   endtask

   // Second reset with a low loop strap
   task automatic t_reset2();
      do_reset('{STRAP_LOW, 5'd0});
      cmd(0, 0, `CMD_LOOP_TUNE, '0, 2'b11, '0);
      cmd(0, 0, `CMD_LOOP_TUNE, '0, 2'b10, 56'h00_0000_000a_0064);
      cmd(0, 1, `CMD_LOOP_TUNE, '0, 2'b10, 56'h00_0000_000a_0064);
      cmd(0, 0, `CMD_ALERT_MASK, '0, 2'b10, 56'h00_0000_0000_0000);
      i_host.idle();
      chk(56'(loopEnable), '0);
      $display("reset test done");
   endtask

   // Main sequence
   initial begin
      faultEvent = '0;
      faultClear = 1'b0;
      genStrap = '{STRAP_LOW, 5'd0};
      syncStrap = '{STRAP_OPEN, 5'd0};
      lockoutStrap = '{STRAP_HIGH, 5'd0};
      vsetStrapA = '{STRAP_RES, 5'd0};
      vsetStrapB = '{STRAP_RES, 5'd31};
      do_reset('{STRAP_RES, 5'd5});
      t_strap();
      t_loop();
      t_alert();
      t_reset2();
      complete_run();
   end
endmodule
`default_nettype wire
